// *** hw/pfi_byte_mux.sv ***
/*
  Per-position byte source selection for the format sector:
  copied, generated or constant zero. Purely combinational.
  Assumes pre_byte is the source byte at the same position.
*/
`timescale 1ns/100ps
module pfi_byte_mux (
  // position
  input  wire logic [10:0] byte_pos,
  input  wire logic [3:0]  sect_idx,
  // sources
  input  wire logic [7:0]  pre_byte,
  input  wire logic [3:0]  rate_code,
  input  wire logic [23:0] max_rec,
  input  wire logic [23:0] l0_field,
  input  wire logic [23:0] border_out,
  input  wire logic [23:0] border_in,
  input  wire logic        border_zero,
  input  wire logic [3:0]  remap_flags,
  // result
  output logic [7:0]       byte_out
);

  // big-endian pick of one byte of a 24-bit sector number
  function automatic logic [7:0] pick(input logic [23:0] v, input logic [10:0] ofs);
    unique case (ofs[1:0])
      2'h0:    pick = v[23:16];
      2'h1:    pick = v[15:8];
      default: pick = v[7:0];
    endcase
  endfunction : pick

  always_comb begin
    byte_out = pre_byte;
    if (sect_idx == pfi_pkg::SECT_MFG) begin
      byte_out = pfi_pkg::MFG_FILL;
    end else if (sect_idx != pfi_pkg::SECT_FORMAT) begin
      byte_out = 8'h00;
    end else if (byte_pos == pfi_pkg::POS_CATEGORY) begin
      byte_out = {pre_byte[7:4], pfi_pkg::LAYER_IND};
    end else if (byte_pos == pfi_pkg::POS_RATE) begin
      byte_out = {pre_byte[7:4], rate_code};
    end else if (byte_pos == pfi_pkg::POS_DZ_PAD || byte_pos == pfi_pkg::POS_MAX_PAD
                 || byte_pos == pfi_pkg::POS_L0_PAD) begin
      byte_out = 8'h00;
    end else if (byte_pos >= pfi_pkg::POS_DZ_START && byte_pos < pfi_pkg::POS_MAX_PAD) begin
      byte_out = pick(pfi_pkg::DATA_ZONE_START, byte_pos - pfi_pkg::POS_DZ_START);
    end else if (byte_pos >= pfi_pkg::POS_MAX_REC && byte_pos < pfi_pkg::POS_L0_PAD) begin
      byte_out = pick(max_rec, byte_pos - pfi_pkg::POS_MAX_REC);
    end else if (byte_pos >= pfi_pkg::POS_L0_REC && byte_pos < 11'h010) begin
      byte_out = pick(l0_field, byte_pos - pfi_pkg::POS_L0_REC);
    end else if (byte_pos >= pfi_pkg::POS_RSV_LO && byte_pos <= pfi_pkg::POS_RSV_HI) begin
      byte_out = 8'h00;
    end else if (byte_pos >= pfi_pkg::POS_BOUT_PAD && byte_pos < 11'h028) begin
      // whole border field collapses to zero when unusable
      if (border_zero || byte_pos == pfi_pkg::POS_BOUT_PAD
          || byte_pos == pfi_pkg::POS_BIN_PAD) begin
        byte_out = 8'h00;
      end else if (byte_pos < pfi_pkg::POS_BIN_PAD) begin
        byte_out = pick(border_out, byte_pos - pfi_pkg::POS_BOUT);
      end else begin
        byte_out = pick(border_in, byte_pos - pfi_pkg::POS_BIN);
      end
    end else if (byte_pos == pfi_pkg::POS_REMAP) begin
      byte_out = {4'h0, remap_flags};
    end else if (byte_pos >= pfi_pkg::POS_ZERO_LO && byte_pos <= pfi_pkg::POS_ZERO_HI) begin
      byte_out = 8'h00;
    end
  end

endmodule : pfi_byte_mux

// *** hw/phys_format_info_builder.sv ***
/*
  Builds the byte stream of the recordable format information zone:
  192 identical 16-sector blocks, format sector first in each block.
  Assumes a source that returns PRE_DATA for PRE_ADDR in the same cycle
  and a sector writer that pulls bytes with OUT_VALID/OUT_READY.
*/
// How it works
// - zone is 192 blocks from sector 02E400
// - inputs frozen so all blocks repeat identically
// - manufacturing sector filled with fixed value
// - unlisted format bytes copied from source
// - byte 0 low nibble forced to 1111
// - byte 1 low nibble only legal rate codes
// - data zone start fields fixed, pads zero
// - bytes 9-11 carry highest recorded sector
// - bytes 13-15 chosen by management format
// - reserved bytes 28-31, 43-511 are zero
// - border out/in starts, pad bytes zero
// - disk-at-once zeroes all border bytes
// - incremental mode passes border starts through
// - format-1 or unused field zeroes border
// - byte 42 holds four remap flags
// - bytes 512-2047 copied from extended source
// - category nibble passed through, checked 0010
`timescale 1ns/100ps
module phys_format_info_builder (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        ARST_N,
  // control and status
  input  wire logic        START,
  output logic             BUSY,
  output logic             ZONE_DONE,
  output logic             CATEGORY_MISMATCH,
  output logic             RATE_CLAMPED,
  // recording state
  input  wire logic [3:0]  RATE_CODE,
  input  wire logic [23:0] MAX_REC_SECTOR,
  input  wire logic [23:0] L0_MAX_REC_SECTOR,
  input  wire logic [23:0] L0_END_SECTOR,
  input  wire logic        L1_RECORDED,
  input  wire logic        MGMT_FORMAT4,
  input  wire logic        DISC_AT_ONCE,
  input  wire logic        BORDER_FIELD_USED,
  input  wire logic [23:0] BORDER_OUT_START,
  input  wire logic [23:0] BORDER_IN_START,
  input  wire logic [3:0]  REMAP_VALID,
  // pre-recorded source
  output logic [10:0]      PRE_ADDR,
  input  wire logic [7:0]  PRE_DATA,
  // sector stream
  output logic [7:0]       OUT_DATA,
  output logic             OUT_VALID,
  input  wire logic        OUT_READY,
  output logic [10:0]      OUT_POS,
  output logic [23:0]      OUT_SECTOR,
  output logic             OUT_SOS,
  output logic             OUT_ZONE_END
);

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_RUN   = 3'b010,
    S_DRAIN = 3'b100
  } state_t;

  state_t      state_ff;
  state_t      nxt_state;

  logic [3:0]  rate_ff;
  logic [23:0] max_rec_ff;
  logic [23:0] l0_field_ff;
  logic [23:0] bout_ff;
  logic [23:0] bin_ff;
  logic        border_zero_ff;
  logic [3:0]  remap_ff;

  logic [10:0] byte_pos;
  logic [3:0]  sect_idx;
  logic [7:0]  block_idx;
  logic        zone_last;
  logic        slot_free;
  logic        load;
  logic        start_ok;
  logic        rate_legal;
  logic [7:0]  nxt_byte;

  logic [7:0]  out_data_ff;
  logic        out_valid_ff;
  logic [10:0] out_pos_ff;
  logic [3:0]  out_sect_ff;
  logic [23:0] out_sector_ff;
  logic        out_end_ff;
  logic        done_ff;
  logic        cat_bad_ff;
  logic        clamp_ff;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  assign slot_free = ~out_valid_ff | OUT_READY;
  assign load      = (state_ff == S_RUN) & slot_free;
  assign start_ok  = (state_ff == S_IDLE) & START;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE:  if (START) nxt_state = S_RUN;
      S_RUN:   if (load && zone_last) nxt_state = S_DRAIN;
      S_DRAIN: if (OUT_READY) nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= S_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= (state_ff == S_DRAIN) & OUT_READY;
    end
  end

  zone_position_counter #(
    .BYTES  (pfi_pkg::SECTOR_BYTES),
    .SECTS  (pfi_pkg::SECTORS_PER_BLOCK),
    .BLOCKS (pfi_pkg::BLOCK_COUNT)
  ) u_pos (
    .clk       (SYS_CLK),
    .rst_n     (ARST_N),
    .clear     (start_ok),
    .step      (load),
    .byte_pos  (byte_pos),
    .sect_idx  (sect_idx),
    .block_idx (block_idx),
    .zone_last (zone_last)
  );

  // ----------------------------------------------------------------
  // recording state snapshot
  // ----------------------------------------------------------------
  // taken once per zone; changes mid-zone would break block repetition
  assign rate_legal = (RATE_CODE == pfi_pkg::RATE_2M52) | (RATE_CODE == pfi_pkg::RATE_5M04)
                    | (RATE_CODE == pfi_pkg::RATE_10M08) | (RATE_CODE == pfi_pkg::RATE_UNSPEC);

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rate_ff        <= pfi_pkg::RATE_UNSPEC;
      max_rec_ff     <= 24'h000000;
      l0_field_ff    <= 24'h000000;
      bout_ff        <= 24'h000000;
      bin_ff         <= 24'h000000;
      border_zero_ff <= 1'b1;
      remap_ff       <= 4'h0;
      clamp_ff       <= 1'b0;
    end else if (start_ok) begin
      rate_ff    <= rate_legal ? RATE_CODE : pfi_pkg::RATE_UNSPEC;
      clamp_ff   <= ~rate_legal;
      max_rec_ff <= MAX_REC_SECTOR;
      if (MGMT_FORMAT4) begin
        l0_field_ff <= L0_END_SECTOR;
      end else if (!L1_RECORDED) begin
        l0_field_ff <= MAX_REC_SECTOR;
      end else begin
        l0_field_ff <= L0_MAX_REC_SECTOR;
      end
      bout_ff        <= BORDER_OUT_START;
      bin_ff         <= BORDER_IN_START;
      border_zero_ff <= DISC_AT_ONCE | ~MGMT_FORMAT4 | ~BORDER_FIELD_USED;
      remap_ff       <= REMAP_VALID;
    end
  end

  pfi_byte_mux u_mux (
    .byte_pos    (byte_pos),
    .sect_idx    (sect_idx),
    .pre_byte    (PRE_DATA),
    .rate_code   (rate_ff),
    .max_rec     (max_rec_ff),
    .l0_field    (l0_field_ff),
    .border_out  (bout_ff),
    .border_in   (bin_ff),
    .border_zero (border_zero_ff),
    .remap_flags (remap_ff),
    .byte_out    (nxt_byte)
  );

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_valid_ff <= 1'b0;
    end else if (load) begin
      out_valid_ff <= 1'b1;
    end else if (OUT_READY) begin
      out_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_data_ff   <= 8'h00;
      out_pos_ff    <= 11'h000;
      out_sect_ff   <= 4'h0;
      out_sector_ff <= 24'h000000;
      out_end_ff    <= 1'b0;
    end else if (load) begin
      out_data_ff   <= nxt_byte;
      out_pos_ff    <= byte_pos;
      out_sect_ff   <= sect_idx;
      out_sector_ff <= pfi_pkg::ZONE_START_SECTOR + {12'h000, block_idx, sect_idx};
      out_end_ff    <= zone_last;
    end
  end

  // sticky per zone; source category should read recordable
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cat_bad_ff <= 1'b0;
    end else if (start_ok) begin
      cat_bad_ff <= 1'b0;
    end else if (load && sect_idx == pfi_pkg::SECT_FORMAT
                 && byte_pos == pfi_pkg::POS_CATEGORY
                 && PRE_DATA[7:4] != pfi_pkg::CATEGORY_REC) begin
      cat_bad_ff <= 1'b1;
    end
  end

  assign PRE_ADDR          = byte_pos;
  assign OUT_DATA          = out_data_ff;
  assign OUT_VALID         = out_valid_ff;
  assign OUT_POS           = out_pos_ff;
  assign OUT_SECTOR        = out_sector_ff;
  assign OUT_SOS           = out_valid_ff & (out_pos_ff == 11'h000);
  assign OUT_ZONE_END      = out_valid_ff & out_end_ff;
  assign BUSY              = (state_ff != S_IDLE);
  assign ZONE_DONE         = done_ff;
  assign CATEGORY_MISMATCH = cat_bad_ff;
  assign RATE_CLAMPED      = clamp_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic fmt_out;
  assign fmt_out = out_valid_ff & (out_sect_ff == pfi_pkg::SECT_FORMAT);

  property p_zone_span;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    OUT_ZONE_END |-> (OUT_SECTOR == 24'h02efff) && (OUT_POS == 11'h7ff);
  endproperty
  a_zone_span: assert property (p_zone_span)
    else $error("zone end not at last sector of range");

  property p_frozen;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    (state_ff == S_RUN) |=> $stable(rate_ff) && $stable(max_rec_ff) && $stable(remap_ff);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("recording snapshot changed during zone");

  property p_layer;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    fmt_out && (OUT_POS == 11'h000) |-> OUT_DATA[3:0] == 4'hf;
  endproperty
  a_layer: assert property (p_layer)
    else $error("layer indicator not 1111");

  property p_rate;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    fmt_out && (OUT_POS == 11'h001)
      |-> OUT_DATA[3:0] inside {4'h0, 4'h1, 4'h2, 4'hf};
  endproperty
  a_rate: assert property (p_rate)
    else $error("illegal transfer rate code");

  property p_dz_start;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    fmt_out && (OUT_POS >= 11'h004) && (OUT_POS <= 11'h008)
      |-> OUT_DATA == ((OUT_POS == 11'h005) ? 8'h03 : 8'h00);
  endproperty
  a_dz_start: assert property (p_dz_start)
    else $error("data zone start field wrong");

  property p_reserved;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    fmt_out && (((OUT_POS >= 11'h01c) && (OUT_POS <= 11'h01f))
      || ((OUT_POS >= 11'h02b) && (OUT_POS <= 11'h1ff))) |-> OUT_DATA == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved byte not zero");

  property p_dao_border;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    fmt_out && border_zero_ff && (OUT_POS >= 11'h020) && (OUT_POS <= 11'h027)
      |-> OUT_DATA == 8'h00;
  endproperty
  a_dao_border: assert property (p_dao_border)
    else $error("border byte not zero when field unusable");

  property p_remap;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    fmt_out && (OUT_POS == 11'h02a) |-> OUT_DATA == {4'h0, remap_ff};
  endproperty
  a_remap: assert property (p_remap)
    else $error("remap flag byte wrong");

  property p_ext_copy;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    load && (sect_idx == pfi_pkg::SECT_FORMAT) && (byte_pos >= 11'h200)
      |=> OUT_DATA == $past(PRE_DATA);
  endproperty
  a_ext_copy: assert property (p_ext_copy)
    else $error("extended byte not copied");

  property p_hold;
    @(posedge SYS_CLK) disable iff (!ARST_N)
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_POS);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stream byte dropped under back-pressure");

endmodule : phys_format_info_builder

// *** hw/zone_position_counter.sv ***
/*
  Byte, sector and block position counters for one pass over the zone.
  Assumes clear and step are never high together.
*/
`timescale 1ns/100ps
module zone_position_counter #(
  parameter int BYTES  = 2048,
  parameter int SECTS  = 16,
  parameter int BLOCKS = 192
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // control
  input  wire logic                      clear,
  input  wire logic                      step,
  // position
  output logic [$clog2(BYTES)-1:0]       byte_pos,
  output logic [$clog2(SECTS)-1:0]       sect_idx,
  output logic [$clog2(BLOCKS)-1:0]      block_idx,
  output logic                           zone_last
);

  localparam int BW = $clog2(BYTES);
  localparam int SW = $clog2(SECTS);
  localparam int KW = $clog2(BLOCKS);

  logic byte_last;
  logic sect_last;
  logic block_last;

  assign byte_last  = (byte_pos == BW'(BYTES - 1));
  assign sect_last  = (sect_idx == SW'(SECTS - 1));
  assign block_last = (block_idx == KW'(BLOCKS - 1));
  assign zone_last  = byte_last & sect_last & block_last;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_pos <= '0;
    end else if (clear || (step && byte_last)) begin
      byte_pos <= '0;
    end else if (step) begin
      byte_pos <= byte_pos + BW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sect_idx <= '0;
    end else if (clear || (step && byte_last && sect_last)) begin
      sect_idx <= '0;
    end else if (step && byte_last) begin
      sect_idx <= sect_idx + SW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      block_idx <= '0;
    end else if (clear || (step && zone_last)) begin
      block_idx <= '0;
    end else if (step && byte_last && sect_last) begin
      block_idx <= block_idx + KW'(1);
    end
  end

endmodule : zone_position_counter

// *** pkg/pfi_pkg.sv ***
/*
  Constants for the recordable format information zone builder:
  zone geometry, byte positions of generated fields and fixed codes.
  Assumes a byte-wide stream and 24-bit sector numbers.
*/
package pfi_pkg;

  // ----------------------------------------------------------------
  // zone geometry
  // ----------------------------------------------------------------
  localparam logic [23:0] ZONE_START_SECTOR = 24'h02e400;
  localparam int          BLOCK_COUNT       = 192;
  localparam int          SECTORS_PER_BLOCK = 16;
  localparam int          ZONE_SECTORS      = 3072;
  localparam int          SECTOR_BYTES      = 2048;
  localparam logic [3:0]  SECT_FORMAT       = 4'h0;
  localparam logic [3:0]  SECT_MFG          = 4'h1;
  localparam logic [7:0]  MFG_FILL          = 8'h00;

  // ----------------------------------------------------------------
  // byte positions
  // ----------------------------------------------------------------
  localparam logic [10:0] POS_CATEGORY = 11'h000;
  localparam logic [10:0] POS_RATE     = 11'h001;
  localparam logic [10:0] POS_DZ_PAD   = 11'h004;
  localparam logic [10:0] POS_DZ_START = 11'h005;
  localparam logic [10:0] POS_MAX_PAD  = 11'h008;
  localparam logic [10:0] POS_MAX_REC  = 11'h009;
  localparam logic [10:0] POS_L0_PAD   = 11'h00c;
  localparam logic [10:0] POS_L0_REC   = 11'h00d;
  localparam logic [10:0] POS_RSV_LO   = 11'h01c;
  localparam logic [10:0] POS_RSV_HI   = 11'h01f;
  localparam logic [10:0] POS_BOUT_PAD = 11'h020;
  localparam logic [10:0] POS_BOUT     = 11'h021;
  localparam logic [10:0] POS_BIN_PAD  = 11'h024;
  localparam logic [10:0] POS_BIN      = 11'h025;
  localparam logic [10:0] POS_REMAP    = 11'h02a;
  localparam logic [10:0] POS_ZERO_LO  = 11'h02b;
  localparam logic [10:0] POS_ZERO_HI  = 11'h1ff;
  localparam logic [10:0] POS_EXT_LO   = 11'h200;

  // ----------------------------------------------------------------
  // field codes
  // ----------------------------------------------------------------
  localparam logic [23:0] DATA_ZONE_START = 24'h030000;
  localparam logic [3:0]  LAYER_IND       = 4'hf;
  localparam logic [3:0]  CATEGORY_REC    = 4'h2;
  localparam logic [3:0]  RATE_2M52       = 4'h0;
  localparam logic [3:0]  RATE_5M04       = 4'h1;
  localparam logic [3:0]  RATE_10M08      = 4'h2;
  localparam logic [3:0]  RATE_UNSPEC     = 4'hf;

endpackage : pfi_pkg

// *** sim/phys_format_info_builder_tb.sv ***
/*
  Self-checking bench for the format information zone builder.
  Assumes the source model answers combinationally; passes are cut
  short by reset after two sectors, a full zone being far too long.
*/
`timescale 1ns/100ps
module phys_format_info_builder_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [23:0] MAXR = 24'h0412a7;
  localparam logic [23:0] L0M  = 24'h01f3c5;
  localparam logic [23:0] L0E  = 24'h02a1e0;
  localparam logic [23:0] BOS  = 24'h031b00;
  localparam logic [23:0] BIS  = 24'h0321c0;
  localparam logic [23:0] ZONE_START = 24'h02e400;
  logic        SYS_CLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic        START = 1'b0;
  logic [3:0]  RATE_CODE = 4'h0;
  logic [23:0] MAX_REC_SECTOR = 24'h000000;
  logic [23:0] L0_MAX_REC_SECTOR = 24'h000000;
  logic [23:0] L0_END_SECTOR = 24'h000000;
  logic        L1_RECORDED = 1'b0;
  logic        MGMT_FORMAT4 = 1'b0;
  logic        DISC_AT_ONCE = 1'b0;
  logic        BORDER_FIELD_USED = 1'b0;
  logic [23:0] BORDER_OUT_START = 24'h000000;
  logic [23:0] BORDER_IN_START = 24'h000000;
  logic [3:0]  REMAP_VALID = 4'h0;
  logic        OUT_READY = 1'b1;
  logic        cat_bad = 1'b0;
  logic        BUSY, ZONE_DONE, CATEGORY_MISMATCH, RATE_CLAMPED;
  logic [10:0] PRE_ADDR, OUT_POS;
  logic [7:0]  PRE_DATA, OUT_DATA;
  logic [23:0] OUT_SECTOR;
  logic        OUT_VALID, OUT_SOS, OUT_ZONE_END;
  logic [3:0]  e_rate, e_rmp;
  logic [23:0] e_l0;
  logic        e_bon;
  logic [7:0]  cap [2048];
  int          fails = 0;
  int          compares = 0;

  always #5 SYS_CLK = ~SYS_CLK;

  phys_format_info_builder u_dut (
    .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .START(START), .BUSY(BUSY),
    .ZONE_DONE(ZONE_DONE), .CATEGORY_MISMATCH(CATEGORY_MISMATCH),
    .RATE_CLAMPED(RATE_CLAMPED), .RATE_CODE(RATE_CODE),
    .MAX_REC_SECTOR(MAX_REC_SECTOR), .L0_MAX_REC_SECTOR(L0_MAX_REC_SECTOR),
    .L0_END_SECTOR(L0_END_SECTOR), .L1_RECORDED(L1_RECORDED),
    .MGMT_FORMAT4(MGMT_FORMAT4), .DISC_AT_ONCE(DISC_AT_ONCE),
    .BORDER_FIELD_USED(BORDER_FIELD_USED), .BORDER_OUT_START(BORDER_OUT_START),
    .BORDER_IN_START(BORDER_IN_START), .REMAP_VALID(REMAP_VALID),
    .PRE_ADDR(PRE_ADDR), .PRE_DATA(PRE_DATA), .OUT_DATA(OUT_DATA),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_POS(OUT_POS),
    .OUT_SECTOR(OUT_SECTOR), .OUT_SOS(OUT_SOS), .OUT_ZONE_END(OUT_ZONE_END)
  );

  pre_format_source u_src (.addr(PRE_ADDR), .cat_bad(cat_bad), .data(PRE_DATA));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  function automatic logic [7:0] exp_b(input int a);
    logic [7:0] s;
    s = u_src.src_byte(11'(a), cat_bad);
    if (a == 0) return {s[7:4], 4'hf};
    if (a == 1) return {s[7:4], e_rate};
    if (a >= 5 && a <= 7) return (a == 5) ? 8'h03 : 8'h00;
    if (a >= 9 && a <= 11) return MAXR[8*(11-a) +: 8];
    if (a >= 13 && a <= 15) return e_l0[8*(15-a) +: 8];
    if (a >= 33 && a <= 35) return e_bon ? BOS[8*(35-a) +: 8] : 8'h00;
    if (a >= 37 && a <= 39) return e_bon ? BIS[8*(39-a) +: 8] : 8'h00;
    if (a == 42) return {4'h0, e_rmp};
    if (a == 4 || a == 8 || a == 12 || (a >= 28 && a <= 36)) return 8'h00;
    if (a >= 43 && a <= 511) return 8'h00;
    return s;
  endfunction : exp_b

  function automatic logic [23:0] get24(input int a);
    return {cap[a], cap[a+1], cap[a+2]};
  endfunction : get24

  task automatic abort_pass;
    ARST_N = 1'b0;
    repeat (3) @(posedge SYS_CLK);
    #1 ARST_N = 1'b1;
    chk(24'({BUSY, OUT_VALID, CATEGORY_MISMATCH}), 24'h000000);
  endtask : abort_pass

  // one pass over the format and manufacturing sectors, ready stalling
  task automatic run_pass(input logic [3:0] rate, erate, input logic f4, l1,
                          dao, used, input logic [3:0] rmp, input logic bad);
    int p;
    RATE_CODE = rate; MAX_REC_SECTOR = MAXR; L0_MAX_REC_SECTOR = L0M;
    L0_END_SECTOR = L0E; BORDER_OUT_START = BOS; BORDER_IN_START = BIS;
    MGMT_FORMAT4 = f4; L1_RECORDED = l1; DISC_AT_ONCE = dao;
    BORDER_FIELD_USED = used; REMAP_VALID = rmp; cat_bad = bad;
    e_rate = erate; e_rmp = rmp; e_bon = f4 && used && !dao;
    e_l0 = f4 ? L0E : (l1 ? L0M : MAXR);
    START = 1'b1;
    @(posedge SYS_CLK);
    #1 START = 1'b0;
    RATE_CODE = ~rate; MAX_REC_SECTOR = ~MAXR; REMAP_VALID = ~rmp;
    // stall byte 0 until the loop watches, so no accept goes unseen
    OUT_READY = 1'b0;
    @(posedge SYS_CLK);
    #1 START = 1'b1;
    @(posedge SYS_CLK);
    #1 START = 1'b0;
    p = 0;
    for (int k = 0; k < 6000 && p < 4096; k++) begin
      @(negedge SYS_CLK);
      if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
        chk(24'(OUT_POS), 24'(p % 2048));
        chk(OUT_SECTOR, ZONE_START + 24'(p / 2048));
        chk(24'(OUT_SOS), 24'(p % 2048 == 0));
        chk(24'(PRE_ADDR), 24'((p + 1) % 2048));
        chk(24'({ZONE_DONE, OUT_ZONE_END}), 24'h000000);
        if (p < 2048) begin
          chk(24'(OUT_DATA), 24'(exp_b(p)));
          cap[p] = OUT_DATA;
        end else begin
          chk(24'(OUT_DATA), 24'h000000);
        end
        p++;
      end
      @(posedge SYS_CLK);
      #1 OUT_READY = (k % 5 != 2);
    end
    chk(24'(p), 24'd4096);
  endtask : run_pass

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic scen_incremental;
    run_pass(4'h2, 4'h2, 1'b1, 1'b0, 1'b0, 1'b1, 4'ha, 1'b0);
    chk(get24(13), L0E);
    chk(get24(33), BOS);
    chk(get24(37), BIS);
    chk(24'({cap[32], cap[36]}), 24'h000000);
    chk(24'(cap[42]), 24'h00000a);
    // reader view: each flag picks original or anchor_point_data copy
    for (int n = 0; n < 4; n++) begin
      if (e_rmp[n]) chk(24'(cap[42][n]), 24'h000001);
      else chk(24'(cap[42][n]), 24'h000000);
    end
    chk(get24(5), 24'h030000);
    chk(24'(RATE_CLAMPED), 24'h000000);
    for (int i = 43; i < 512; i++) chk(24'(cap[i]), 24'h000000);
    for (int i = 512; i < 2048; i++) chk(24'(cap[i]), 24'(u_src.src_byte(11'(i), 1'b0)));
    abort_pass();
  endtask : scen_incremental

  task automatic scen_disc_at_once;
    run_pass(4'h5, 4'hf, 1'b1, 1'b0, 1'b1, 1'b1, 4'h5, 1'b0);
    chk(24'(RATE_CLAMPED), 24'h000001);
    chk(get24(33), 24'h000000);
    chk(get24(37), 24'h000000);
    abort_pass();
  endtask : scen_disc_at_once

  task automatic scen_format1;
    run_pass(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h1, 1'b0);
    chk(get24(13), MAXR);
    chk(get24(33), 24'h000000);
    chk(24'(cap[0]), 24'h00002f);
    chk(24'(CATEGORY_MISMATCH), 24'h000000);
    abort_pass();
    run_pass(4'h1, 4'h1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h8, 1'b1);
    chk(get24(13), L0M);
    chk(24'(cap[0]), 24'h00003f);
    chk(24'(CATEGORY_MISMATCH), 24'h000001);
    abort_pass();
  endtask : scen_format1

  task automatic scen_border_unused;
    run_pass(4'hf, 4'hf, 1'b1, 1'b1, 1'b0, 1'b0, 4'h3, 1'b0);
    chk(get24(37), 24'h000000);
    chk(24'(RATE_CLAMPED), 24'h000000);
    abort_pass();
  endtask : scen_border_unused

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge SYS_CLK);
    #1 ARST_N = 1'b1;
    chk(24'({BUSY, OUT_VALID}), 24'h000000);
    scen_incremental();
    scen_disc_at_once();
    scen_format1();
    scen_border_unused();
    finish_test();
  end

  // five passes of about 5200 cycles each, with generous margin
  initial begin
    #600000;
    fails++;
    finish_test();
  end
endmodule : phys_format_info_builder_tb

// *** sim/pre_format_source.sv ***
/*
  Model of the pre-recorded format information source.
  Assumes the builder reads one byte per cycle and wants it at once.
*/
`timescale 1ns/100ps
module pre_format_source (
  // source port
  input  wire logic [10:0] addr,
  input  wire logic        cat_bad,
  output logic [7:0]       data
);
  // ----------------------------------------------------------------
  // byte pattern
  // ----------------------------------------------------------------
  // position-dependent pattern so a wrong address shows as wrong data
  function automatic logic [7:0] src_byte(input logic [10:0] a, input logic bad);
    if (a == 11'h000) begin
      return bad ? 8'h36 : 8'h26;
    end
    return {a[3:0], a[7:4]} ^ {5'h00, a[10:8]};
  endfunction : src_byte

  // combinational answer, the builder gives no wait cycle
  assign data = src_byte(addr, cat_bad);
endmodule : pre_format_source
